// ===== design/mms_pkg.sv
// mms_pkg: constants and types shared by the memory map / security block.
// assumes a 16-bit data bus, 23-bit program address, one 40 MHz clock.
package mms_pkg;
	// register port map
	localparam logic [3:0]  ADDR_MODE     = 4'h0; // processor_mode_register
	localparam logic [3:0]  ADDR_SECURITY = 4'h1; // security option select
	localparam logic [3:0]  ADDR_STATUS   = 4'h2; // decode status readback
	// processor_mode_register fields
	localparam int          PTR_MSB       = 15;
	localparam int          PTR_LSB       = 7;
	localparam int          ROMDIS_BIT    = 6;
	localparam int          OVERLAY_BIT   = 5;
	localparam int          UPPER_MAP_BIT = 3;
	localparam logic [8:0]  PTR_RESET     = 9'h1FF;
	localparam logic [5:0]  LOW_RESET     = 6'h00;
	// security encodings
	localparam logic [1:0]  SEC_NONE      = 2'h0;
	localparam logic [1:0]  SEC_RAM_ROM   = 2'h1;
	localparam logic [1:0]  SEC_ROM_ONLY  = 2'h2;
	localparam logic [15:0] SECURE_FILL   = 16'hFFFF;
	// host_port read window under ram/rom security
	localparam logic [15:0] HOST_RD_LO    = 16'h4000;
	localparam logic [15:0] HOST_RD_HI    = 16'h5FFF;
	// address map
	localparam logic [15:0] PAGE0_TOP     = 16'h007F;
	localparam logic [15:0] LOWER_RAM_TOP = 16'h7FFF;
	localparam logic [15:0] ROM_BASE      = 16'hC000;
	localparam logic [6:0]  DUAL_XPAGE    = 7'h01;
	localparam logic [6:0]  SINGLE_XPAGE0 = 7'h02;
	localparam logic [6:0]  SINGLE_XPAGE1 = 7'h03;
	localparam logic [15:0] UPPER_HALF    = 16'h8000;

	// memory region targets
	typedef enum logic [2:0] {
		MMS_EXT, MMS_DUAL, MMS_SINGLE, MMS_ROM, MMS_PAGE0
	} mms_region_t;
endpackage : mms_pkg

// ===== design/mms_memory_map_security.sv
// mms_memory_map_security: address decode, rom read filter, host port
// filter, vector address generation and the processor mode register.
// assumes core buses synchronous to clk; memories answer outside this block.
// design notes
// every output is registered: each answer trails its inputs by one edge.
// the core holds address and strobes for one cycle; nothing is queued here.
// the memories live outside this block; it only steers and filters.
// one clock, one synchronous active-low reset; no second domain anywhere.
//
// register port
// a write lands at the edge that sees the write strobe.
// a read is answered in the cycle after the read strobe, zero otherwise.
// address 0 is the mode register, 1 the latched option, 2 a status word.
// option and status are read only; writes to them are dropped silently.
// unmapped addresses read as zero so software can probe safely.
//
// mode register layout
// bits 15..7 vector page, bit 6 rom removal, bits 5..0 plain storage.
// of bits 5..0 only bits 5 and 3 steer the decode; the rest are kept for software.
// the reset instruction clears bits 5..0 and nothing else.
// a write in the same cycle as the reset instruction wins over it.
//
// option latching
// the security option and the mode pin are caught while reset is held.
// the option never moves afterwards, so a glitch on the strap is harmless.
// code 3 on the option strap is treated as no security at all.
// under ram/rom security the rom bit starts at zero whatever the pin says.
// software may still set the rom bit later; the option does not lock it.
//
// program decode
// the seven upper address bits choose the extended page.
// page 1 upper half is dual ram 4..7; pages 2 and 3 upper halves single ram.
// rom answers the top quarter of any page but 1..3 when the rom bit is clear.
// overlay maps the lower dual ram into program space, page 0 excepted.
// anything else goes to the external bus.
// a branch into rom is never refused: fetch decode ignores security.
//
// data decode
// addresses up to 7Fh are the core's own page 0, outside this block.
// 0080h..7FFFh are dual ram blocks 0..3, always present.
// 8000h..FFFFh are dual ram 4..7 only while bit 3 is set.
// with bit 3 clear those addresses leave the chip.
// the block index is simply the top three address bits.
//
// rom read filter
// the origin of the most recent fetch is remembered in one flop.
// a data read is judged against fetches of earlier cycles only.
// the rom window is judged in the same cycle as the read it filters;
// pairing a late flag with fresh memory data would mask the wrong word.
// with bit 3 set the upper data space is ram, so the filter stands down.
// ram contents always pass untouched, whatever fetched the reader.
// limitation: code fetched from ram can still leak ram; only rom is guarded.
//
// host port filter
// writes are granted in every option.
// under ram/rom security reads are granted only in 4000h..5FFFh.
// rom-only security and no security grant every read.
// a refused read simply sees its grant low; no error is raised here.
//
// vectors
// a taken vector loads the pc one cycle later with a single pulse.
// each vector owns four words, so the number is shifted left by two.
// the page pointer supplies the upper nine bits of the address.
// a hardware reset vector ignores the pointer and uses the all-ones page.
// the pc output holds until the next vector is taken.
//
// emulation
// scan emulation is off in both security options.
// boundary scan stays usable; it drops only while reset is held.
// both are flops, so they never glitch on a strap change.
//
// trade-offs
// decode is registered to keep the core's timing path short,
// at the price of one cycle of latency on every answer.
// no arbitration: the core and the host port are judged independently.
// the status word exists for bring-up; it costs six bits of readback.
//
`timescale 1ns/1ps
`default_nettype none
module mms_memory_map_security (
	input  wire logic        clk,
	input  wire logic        rst_b,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// straps
	input  wire logic        rom_disable_mode_pin,
	input  wire logic [1:0]  security_option,
	input  wire logic        soft_reset,
	// program fetch decode
	input  wire logic [22:0] prog_addr,
	input  wire logic        prog_fetch,
	output logic      [2:0]  prog_region,
	output logic      [2:0]  prog_block,
	output logic             fetch_from_rom,
	// data read decode and filter
	input  wire logic [15:0] data_addr,
	input  wire logic        data_rd,
	input  wire logic [15:0] data_mem_rdata,
	output logic      [2:0]  data_region,
	output logic      [2:0]  data_block,
	output logic             data_external,
	output logic      [15:0] data_rdata,
	// host_port access filter
	input  wire logic [15:0] host_addr,
	input  wire logic        host_rd,
	input  wire logic        host_wr,
	output logic             host_rd_grant,
	output logic             host_wr_grant,
	// vector generation
	input  wire logic        vector_take,
	input  wire logic [4:0]  vector_num,
	input  wire logic        vector_is_hw_reset,
	output logic      [15:0] vector_pc,
	output logic             vector_load,
	// emulation control
	output logic             scan_emu_enable,
	output logic             boundary_scan_enable
);
	////////////////////////////////////////////////////////////////////////
	// state record
	typedef struct packed {
		logic [8:0]  vec_ptr;
		logic        rom_dis;
		logic [5:0]  low_bits;
		logic [1:0]  sec;
		logic        bscan;
		logic        rom_fetch_src;
		logic [15:0] rdata;
		logic [2:0]  p_region;
		logic [2:0]  p_block;
		logic        fetch_rom;
		logic [2:0]  d_region;
		logic [2:0]  d_block;
		logic        d_ext;
		logic        d_rom_read;
		logic [15:0] d_rdata;
		logic        h_rd;
		logic        h_wr;
		logic [15:0] v_pc;
		logic        v_load;
		logic        emu_en;
	} mms_state_t;

	mms_state_t st;
	mms_state_t next_st;

	////////////////////////////////////////////////////////////////////////
	// decode helpers

	// secured under either option
	function automatic logic mms_secure(input logic [1:0] s);
		mms_secure = (s == mms_pkg::SEC_RAM_ROM) || (s == mms_pkg::SEC_ROM_ONLY);
	endfunction : mms_secure

	// data space decode; block index is the top three address bits
	function automatic mms_pkg::mms_region_t mms_data_dec(
		input logic [15:0] a,
		input logic        upper_map
	);
		if (a <= mms_pkg::PAGE0_TOP) begin
			mms_data_dec = mms_pkg::MMS_PAGE0;
		end else if (a <= mms_pkg::LOWER_RAM_TOP) begin
			mms_data_dec = mms_pkg::MMS_DUAL;
		end else if (upper_map) begin
			mms_data_dec = mms_pkg::MMS_DUAL;
		end else begin
			mms_data_dec = mms_pkg::MMS_EXT;
		end
	endfunction : mms_data_dec

	// program space decode over the 23-bit address
	function automatic mms_pkg::mms_region_t mms_prog_dec(
		input logic [22:0] a,
		input logic        overlay,
		input logic        rom_disabled
	);
		logic [6:0]  pg;
		logic [15:0] off;
		pg  = a[22:16];
		off = a[15:0];
		if (pg == mms_pkg::DUAL_XPAGE && off >= mms_pkg::UPPER_HALF) begin
			mms_prog_dec = mms_pkg::MMS_DUAL;
		end else if ((pg == mms_pkg::SINGLE_XPAGE0 || pg == mms_pkg::SINGLE_XPAGE1)
				&& off >= mms_pkg::UPPER_HALF) begin
			mms_prog_dec = mms_pkg::MMS_SINGLE;
		end else if (!rom_disabled && off >= mms_pkg::ROM_BASE) begin
			mms_prog_dec = mms_pkg::MMS_ROM;
		end else if (overlay && off > mms_pkg::PAGE0_TOP && off <= mms_pkg::LOWER_RAM_TOP) begin
			mms_prog_dec = mms_pkg::MMS_DUAL;
		end else begin
			mms_prog_dec = mms_pkg::MMS_EXT;
		end
	endfunction : mms_prog_dec

	// single ram block: page 3 holds blocks 4..7, page 2 blocks 0..3
	function automatic logic [2:0] mms_prog_block(input logic [22:0] a);
		if (a[22:16] == mms_pkg::SINGLE_XPAGE1) begin
			mms_prog_block = {1'b1, a[14:13]};
		end else if (a[22:16] == mms_pkg::SINGLE_XPAGE0) begin
			mms_prog_block = {1'b0, a[14:13]};
		end else begin
			mms_prog_block = a[15:13];
		end
	endfunction : mms_prog_block

	////////////////////////////////////////////////////////////////////////
	// next-state logic
	always_comb begin
		mms_pkg::mms_region_t pr;
		mms_pkg::mms_region_t dr;
		logic                 sec_on;
		logic                 rom_rd;
		pr      = mms_pkg::MMS_EXT;
		rom_rd  = 1'b0;
		dr      = mms_pkg::MMS_EXT;
		next_st = st;
		sec_on  = mms_secure(st.sec);

		if (!rst_b) begin
			// pin and option caught while reset is held
			next_st.vec_ptr       = mms_pkg::PTR_RESET;
			next_st.low_bits      = mms_pkg::LOW_RESET;
			next_st.sec           = security_option;
			next_st.bscan         = 1'b0;
			next_st.rom_fetch_src = 1'b0;
			next_st.rdata         = 16'h0000;
			next_st.p_region      = 3'h0;
			next_st.p_block       = 3'h0;
			next_st.fetch_rom     = 1'b0;
			next_st.d_region      = 3'h0;
			next_st.d_block       = 3'h0;
			next_st.d_ext         = 1'b0;
			next_st.d_rom_read    = 1'b0;
			next_st.d_rdata       = 16'h0000;
			next_st.h_rd          = 1'b0;
			next_st.h_wr          = 1'b0;
			next_st.v_pc          = 16'h0000;
			next_st.v_load        = 1'b0;
			next_st.emu_en        = 1'b0;
			if (security_option == mms_pkg::SEC_RAM_ROM) begin
				next_st.rom_dis = 1'b0;
			end else begin
				next_st.rom_dis = rom_disable_mode_pin;
			end
		end else begin
			next_st.bscan = 1'b1;
			// soft_reset deliberately leaves pointer and rom bit alone
			if (soft_reset) begin
				next_st.low_bits = mms_pkg::LOW_RESET;
			end

			// register write; rom bit writable in every option
			if (reg_wr && reg_addr == mms_pkg::ADDR_MODE) begin
				next_st.vec_ptr  = reg_wdata[mms_pkg::PTR_MSB:mms_pkg::PTR_LSB];
				next_st.rom_dis  = reg_wdata[mms_pkg::ROMDIS_BIT];
				next_st.low_bits = reg_wdata[5:0];
			end

			// register read, answered the cycle after
			next_st.rdata = 16'h0000;
			if (reg_rd) begin
				if (reg_addr == mms_pkg::ADDR_MODE) begin
					next_st.rdata = {st.vec_ptr, st.rom_dis, st.low_bits};
				end else if (reg_addr == mms_pkg::ADDR_SECURITY) begin
					next_st.rdata = {14'h0000, st.sec};
				end else if (reg_addr == mms_pkg::ADDR_STATUS) begin
					next_st.rdata = {10'h000, st.emu_en, st.rom_fetch_src,
						st.d_ext, st.fetch_rom, st.h_rd, st.h_wr};
				end else begin
					next_st.rdata = 16'h0000;
				end
			end

			// program decode; a branch into rom is never blocked
			pr = mms_prog_dec(prog_addr, st.low_bits[mms_pkg::OVERLAY_BIT],
				st.rom_dis);
			next_st.p_region  = pr;
			next_st.p_block   = mms_prog_block(prog_addr);
			next_st.fetch_rom = prog_fetch && (pr == mms_pkg::MMS_ROM);
			if (prog_fetch) begin
				next_st.rom_fetch_src = (pr == mms_pkg::MMS_ROM);
			end

			// data decode
			dr = mms_data_dec(data_addr, st.low_bits[mms_pkg::UPPER_MAP_BIT]);
			next_st.d_region   = dr;
			next_st.d_block    = data_addr[15:13];
			next_st.d_ext      = data_rd && (dr == mms_pkg::MMS_EXT);
			// judged now, beside the memory data that it filters
			rom_rd = data_rd && !st.rom_dis
				&& data_addr >= mms_pkg::ROM_BASE
				&& !st.low_bits[mms_pkg::UPPER_MAP_BIT];
			next_st.d_rom_read = rom_rd;

			// rom data filtered by fetch origin; ram passes untouched
			if (sec_on && rom_rd && !st.rom_fetch_src) begin
				next_st.d_rdata = mms_pkg::SECURE_FILL;
			end else begin
				next_st.d_rdata = data_mem_rdata;
			end

			// host_port filter
			next_st.h_wr = host_wr;
			if (st.sec == mms_pkg::SEC_RAM_ROM) begin
				next_st.h_rd = host_rd && host_addr >= mms_pkg::HOST_RD_LO
					&& host_addr <= mms_pkg::HOST_RD_HI;
			end else begin
				next_st.h_rd = host_rd;
			end

			// vectors: hardware reset always uses the all-ones page
			next_st.v_load = vector_take;
			if (vector_take) begin
				if (vector_is_hw_reset) begin
					next_st.v_pc = {mms_pkg::PTR_RESET, 7'h00};
				end else begin
					next_st.v_pc = {st.vec_ptr, vector_num, 2'b00};
				end
			end

			next_st.emu_en = !sec_on;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	////////////////////////////////////////////////////////////////////////
	// outputs straight from flops
	assign reg_rdata            = st.rdata;
	assign prog_region          = st.p_region;
	assign prog_block           = st.p_block;
	assign fetch_from_rom       = st.fetch_rom;
	assign data_region          = st.d_region;
	assign data_block           = st.d_block;
	assign data_external        = st.d_ext;
	assign data_rdata           = st.d_rdata;
	assign host_rd_grant        = st.h_rd;
	assign host_wr_grant        = st.h_wr;
	assign vector_pc            = st.v_pc;
	assign vector_load          = st.v_load;
	assign scan_emu_enable      = st.emu_en;
	assign boundary_scan_enable = st.bscan;
endmodule : mms_memory_map_security
`default_nettype wire

// ===== tb/mms_core_model.sv
// mms_core_model: data memory that answers the core's data bus.
// combinational answer; the core holds its address for the whole cycle.
`timescale 1ns/1ps
`default_nettype none
module mms_core_model (
	input  wire logic [15:0] addr,
	output logic      [15:0] rdata
);
	// the pattern comes from the address, so every word differs
	assign rdata = {addr[7:0] ^ 8'hA5, addr[15:8]};
endmodule : mms_core_model
`default_nettype wire

// ===== tb/mms_assertions.sv
// mms_assertions: port-level checks of the memory map and security block.
// bound to the top module; one clock domain, synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module mms_assertions (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic [1:0]  security_option,
	input wire logic [15:0] data_addr,
	input wire logic        data_rd,
	input wire logic [15:0] data_mem_rdata,
	input wire logic [15:0] data_rdata,
	input wire logic        data_external,
	input wire logic [15:0] host_addr,
	input wire logic        host_rd,
	input wire logic        host_wr,
	input wire logic        host_rd_grant,
	input wire logic        host_wr_grant,
	input wire logic        vector_take,
	input wire logic [4:0]  vector_num,
	input wire logic        vector_is_hw_reset,
	input wire logic [15:0] vector_pc,
	input wire logic        vector_load,
	input wire logic        scan_emu_enable,
	input wire logic        boundary_scan_enable
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	//////////////////////////////////////////////////////////////////
	// vector steps: a taken vector, then its load one cycle later
	sequence s_take;
		vector_take && !vector_is_hw_reset;
	endsequence
	sequence s_loaded;
		vector_load && vector_pc[6:0] == {$past(vector_num), 2'b00};
	endsequence
	// host port, emulation and ram read filter
	host_rd_window_a: assert property (host_rd && security_option == 2'h1 |=>
		host_rd_grant == ($past(host_addr) inside {[16'h4000:16'h5FFF]}))
		else $error("host read grant wrong under ram/rom security");
	host_wr_free_a: assert property (host_wr |=> host_wr_grant)
		else $error("host write refused");
	emu_blocked_a: assert property (security_option inside {2'h1, 2'h2} |=> !scan_emu_enable)
		else $error("scan emulation left on under security");
	bscan_kept_a: assert property (rst_b |=> boundary_scan_enable)
		else $error("boundary scan disabled");
	ram_read_a: assert property (data_rd && data_addr inside {[16'h0080:16'h7FFF]} |=>
		data_rdata == $past(data_mem_rdata) && !data_external)
		else $error("on-chip ram read altered or sent external");
	// vector generation
	vec_addr_a: assert property (s_take |=> s_loaded)
		else $error("vector address or load wrong");
	vec_reset_a: assert property (vector_take && vector_is_hw_reset |=> vector_pc == 16'hFF80)
		else $error("hardware reset vector not at FF80");
	vec_hold_a: assert property (!vector_take |=> $stable(vector_pc) && !vector_load)
		else $error("vector output moved without a vector");
endmodule : mms_assertions
bind mms_memory_map_security mms_assertions u_chk (.clk, .rst_b, .security_option, .data_addr,
	.data_rd, .data_mem_rdata, .data_rdata, .data_external, .host_addr, .host_rd, .host_wr,
	.host_rd_grant, .host_wr_grant, .vector_take, .vector_num, .vector_is_hw_reset,
	.vector_pc, .vector_load, .scan_emu_enable, .boundary_scan_enable);
`default_nettype wire

// ===== tb/mms_memory_map_security_bench.sv
// mms_memory_map_security_bench: self-checking bench of the memory map block.
// one 40 MHz clock; the core data memory comes from mms_core_model.
`timescale 1ns/1ps
`default_nettype none
module mms_memory_map_security_bench;
	typedef struct {int k; logic [22:0] a; logic [2:0] rg; logic [2:0] bk;} mms_row_t;
	logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, pin = 1'b1;
	logic        soft_reset = 1'b0, prog_fetch = 1'b0, data_rd = 1'b0, host_rd = 1'b0;
	logic        host_wr = 1'b0, vector_take = 1'b0, hw = 1'b0;
	logic [3:0]  reg_addr = 4'h0;
	logic [1:0]  sec = 2'h0;
	logic [4:0]  vector_num = 5'h00;
	logic [22:0] prog_addr = 23'h000000;
	logic [15:0] reg_wdata = 16'h0000, data_addr = 16'h0000, host_addr = 16'h0000;
	logic [15:0] mem_rdata, reg_rdata, data_rdata, vector_pc;
	logic [2:0]  prog_region, prog_block, data_region, data_block;
	logic        fetch_rom, data_ext, h_rd_g, h_wr_g, v_load, emu_en, bscan_en;
	int          err_total = 0, n_compared = 0, cycles = 0;
	// region codes: 0 ext, 1 dual, 2 single, 3 rom; mode 0128 holds overlay and bit 3
	mms_row_t    rows[13] = '{'{0, 23'h018000, 3'h1, 3'h4}, '{0, 23'h01FFFF, 3'h1, 3'h7},
		'{0, 23'h028000, 3'h2, 3'h0}, '{0, 23'h02E000, 3'h2, 3'h3}, '{0, 23'h038000, 3'h2, 3'h4},
		'{0, 23'h03FFFF, 3'h2, 3'h7}, '{0, 23'h004000, 3'h1, 3'h2}, '{0, 23'h00C000, 3'h3, 3'h0},
		'{0, 23'h050000, 3'h0, 3'h0}, '{1, 23'h000080, 3'h1, 3'h0}, '{1, 23'h007FFF, 3'h1, 3'h3},
		'{1, 23'h00A000, 3'h1, 3'h5}, '{1, 23'h00FFFF, 3'h1, 3'h7}};
	logic [15:0] ha[4] = '{16'h3FFF, 16'h4000, 16'h5FFF, 16'h6000};
	mms_memory_map_security u_dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .rom_disable_mode_pin(pin), .security_option(sec), .soft_reset,
		.prog_addr, .prog_fetch, .prog_region, .prog_block, .fetch_from_rom(fetch_rom),
		.data_addr, .data_rd, .data_mem_rdata(mem_rdata), .data_region, .data_block,
		.data_external(data_ext), .data_rdata, .host_addr, .host_rd, .host_wr,
		.host_rd_grant(h_rd_g), .host_wr_grant(h_wr_g), .vector_take, .vector_num,
		.vector_is_hw_reset(hw), .vector_pc, .vector_load(v_load),
		.scan_emu_enable(emu_en), .boundary_scan_enable(bscan_en));
	mms_core_model u_mem (.addr(data_addr), .rdata(mem_rdata));
	//////////////////////////////////////////////////////////////////
	// clock and hang guard; the whole run needs about a hundred cycles
	always #12.5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_total++;
			stop_test();
		end
	end
	function automatic logic [15:0] mem(input logic [15:0] a);
		return {a[7:0] ^ 8'hA5, a[15:8]};
	endfunction : mem
	task automatic chk(input string nm, input logic [22:0] e, input logic [22:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	// reset is a level held eight edges; straps settle during it
	task automatic do_reset(input logic [1:0] opt, input logic p);
		rst_b <= 1'b0;
		sec   <= opt;
		pin   <= p;
		repeat (8) @(posedge clk);
		rst_b <= 1'b1;
	endtask : do_reset
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		{reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge clk);
		{reg_addr, reg_rd} <= {a, 1'b1};
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk("reg_rdata", e, reg_rdata);
	endtask : rd
	// k: 0 fetch, 1 data read, 2 host read, 3 host write, 4 vector; one-cycle strobe
	task automatic acc(input int k, input logic [22:0] a);
		@(posedge clk);
		{prog_addr, data_addr, host_addr, vector_num} <= {a, a[15:0], a[15:0], a[4:0]};
		{prog_fetch, data_rd, host_rd, host_wr, vector_take} <= 5'h10 >> k;
		@(posedge clk);
		{prog_fetch, data_rd, host_rd, host_wr, vector_take} <= 5'h00;
		#1;
	endtask : acc
	initial begin
		do_reset(2'h0, 1'b1);
		rd(4'h0, 16'hFFC0);
		chk("emulation", 1'b1, emu_en);
		rd(4'hF, 16'h0000);
		wr(4'h0, 16'h016F);
		rd(4'h0, 16'h016F);
		acc(0, 23'h00C000);
		chk("rom off", 3'h0, prog_region);
		acc(4, 23'h000003);
		chk("vector_pc", 16'h010C, vector_pc);
		chk("vector_load", 1'b1, v_load);
		hw <= 1'b1;
		acc(4, 23'h000000);
		hw <= 1'b0;
		chk("reset vector", 16'hFF80, vector_pc);
		@(posedge clk) soft_reset <= 1'b1;
		@(posedge clk) soft_reset <= 1'b0;
		rd(4'h0, 16'h0140);
		acc(1, 23'h00A000);
		chk("upper unmapped", 1'b1, data_ext);
		acc(0, 23'h004000);
		chk("no overlay", 3'h0, prog_region);
		wr(4'h0, 16'h0128);
		foreach (rows[i]) begin
			acc(rows[i].k, rows[i].a);
			chk("region", rows[i].rg, rows[i].k ? data_region : prog_region);
			if (rows[i].rg inside {3'h1, 3'h2})
				chk("block", rows[i].bk, rows[i].k ? data_block : prog_block);
			if (rows[i].k == 1)
				chk("ram data", mem(rows[i].a[15:0]), data_rdata);
		end
		// ram/rom security: forced mode bit, host window, rom read filter
		do_reset(2'h1, 1'b1);
		rd(4'h0, 16'hFF80);
		chk("emulation", 1'b0, emu_en);
		chk("boundary scan", 1'b1, bscan_en);
		wr(4'h0, 16'hFFC0);
		rd(4'h0, 16'hFFC0);
		wr(4'h0, 16'hFF80);
		foreach (ha[i]) begin
			acc(2, {7'h00, ha[i]});
			chk("host read", ha[i] inside {[16'h4000:16'h5FFF]}, h_rd_g);
		end
		acc(3, 23'h000000);
		chk("host write", 1'b1, h_wr_g);
		acc(0, 23'h050000);
		acc(1, 23'h00C000);
		chk("rom from ext", 16'hFFFF, data_rdata);
		acc(1, 23'h002000);
		chk("ram from ext", mem(16'h2000), data_rdata);
		acc(0, 23'h00C000);
		chk("branch to rom", 1'b1, fetch_rom);
		acc(1, 23'h00C000);
		chk("rom from rom", mem(16'hC000), data_rdata);
		// rom-only security: pin decides, host port free
		do_reset(2'h2, 1'b1);
		rd(4'h0, 16'hFFC0);
		acc(2, 23'h006000);
		chk("host read free", 1'b1, h_rd_g);
		chk("emulation", 1'b0, emu_en);
		stop_test();
	end
endmodule : mms_memory_map_security_bench
`default_nettype wire
